// >>> include/tbdo_pkg.sv
// constants for the time base and divider output block
// Behaviour
// - the tick function stops while tick_enable is 0 and produces periodic ticks while it is 1.
// - on the high-frequency source, rate codes 000 to 111 divide by 2^23,21,16,14,13,12,11,9.
// - on the low-frequency source, codes divide by 2^15,13,8,6,5,4,3,1; slow mode allows only 000/001.
// - one write may set the rate select and the enable together, with the new rate used at once.
// - once enabled, a tick is raised on the first and every later falling edge of the chosen tap; a fall in the cycle after any control write gives no tick.
// - enabling does not clear the shared divider chain, so the first tick may come early.
// - when enabled, the tone output drives an active-low pin with a roughly 50% square wave.
// - tone codes 00 to 11 divide high-freq by 2^13..2^10 or low-freq by 2^5..2^2.
// - tone_enable sits in bit 7 of the control register and starts the tone when written 1.
// - the rate select sits in bits 2:0 and tick_enable in bit 3 of the control register.
// - the control register reads back the written field values.
package tbdo_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h2;
    localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h3;

    // ****************************************
    // control fields
    // ****************************************
    localparam int RATE_LSB = 0;
    localparam int RATE_W = 3;
    localparam int TICK_EN_BIT = 3;
    localparam int TONE_LSB = 5;
    localparam int TONE_W = 2;
    localparam int TONE_EN_BIT = 7;
    localparam int STAT_TICK_BIT = 0;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] CONTROL_MASK = 8'he8 | 8'h07 | 8'h60;

    // ****************************************
    // divider chain
    // ****************************************
    localparam int CHAIN_W = 23;
    localparam int TONE_HF_TOP_BIT = 12;
    localparam int TONE_LF_TOP_BIT = 4;
endpackage

// >>> core/tbdo_time_base.sv
// time base tick generator and divider tone output
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module tbdo_time_base #(
    parameter int CHAIN_W = tbdo_pkg::CHAIN_W
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // divider chain sources, one-cycle pulses at each source clock rate
    input wire logic i_high_freq_clock,
    input wire logic i_low_freq_clock,
    // operating mode
    input wire logic i_divider_chain_source_select,
    input wire logic i_slow_mode,
    // register port
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // events and pins
    output logic o_tick_interrupt,
    output logic o_irq,
    output logic o_tone_out_n
);
    // ****************************************
    // tap selection
    // ****************************************
    function automatic logic [4:0] tick_tap(input logic [2:0] code, input logic low);
        logic [4:0] t;
        t = 5'h00;
        if (!low) begin
            case (code)
                3'h0: t = 5'h16;
                3'h1: t = 5'h14;
                3'h2: t = 5'h0f;
                3'h3: t = 5'h0d;
                3'h4: t = 5'h0c;
                3'h5: t = 5'h0b;
                3'h6: t = 5'h0a;
                default: t = 5'h08;
            endcase
        end else begin
            case (code)
                3'h0: t = 5'h0e;
                3'h1: t = 5'h0c;
                3'h2: t = 5'h07;
                3'h3: t = 5'h05;
                3'h4: t = 5'h04;
                3'h5: t = 5'h03;
                3'h6: t = 5'h02;
                default: t = 5'h00;
            endcase
        end
        return t;
    endfunction

    logic [CHAIN_W-1:0] chain;
    logic [7:0] control;
    logic tick_stat;
    logic tick_ien;
    logic prev_tap;
    logic armed;

    // ****************************************
    // decode
    // ****************************************
    wire logic use_low = i_slow_mode | i_divider_chain_source_select;
    wire logic src_pulse = use_low ? i_low_freq_clock : i_high_freq_clock;
    wire logic [2:0] rate_sel = control[tbdo_pkg::RATE_LSB +: tbdo_pkg::RATE_W];
    wire logic [1:0] tone_sel = control[tbdo_pkg::TONE_LSB +: tbdo_pkg::TONE_W];
    wire logic tick_en = control[tbdo_pkg::TICK_EN_BIT];
    wire logic tone_en = control[tbdo_pkg::TONE_EN_BIT];
    // slow mode leaves only the two slowest rates
    wire logic rate_ok = !i_slow_mode || (rate_sel[2:1] == 2'h0);
    wire logic [4:0] tick_idx = tick_tap(rate_sel, use_low);
    wire logic tap = chain[tick_idx];
    wire logic [4:0] tone_top = use_low ? 5'(tbdo_pkg::TONE_LF_TOP_BIT)
                                        : 5'(tbdo_pkg::TONE_HF_TOP_BIT);
    wire logic [4:0] tone_idx = tone_top - {3'h0, tone_sel};
    wire logic tone_tap = chain[tone_idx];
    wire logic wr_control = i_wr && (i_addr == tbdo_pkg::ADDR_CONTROL);
    wire logic wr_ien = i_wr && (i_addr == tbdo_pkg::ADDR_IRQ_ENABLE);
    wire logic wr_clear = i_wr && (i_addr == tbdo_pkg::ADDR_IRQ_CLEAR);
    // falling edge of the selected tap while running
    wire logic tick_event = armed && tick_en && rate_ok && prev_tap && !tap;
    wire logic [7:0] next_rdata =
        (i_addr == tbdo_pkg::ADDR_CONTROL) ? control :
        (i_addr == tbdo_pkg::ADDR_STATUS) ? {7'h00, tick_stat} :
        (i_addr == tbdo_pkg::ADDR_IRQ_ENABLE) ? {7'h00, tick_ien} : 8'h00;

    // ****************************************
    // divider chain, never cleared by software
    // ****************************************
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            chain <= '0;
        end else if (src_pulse) begin
            chain <= chain + 1'b1;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            control <= tbdo_pkg::CONTROL_RESET;
            tick_ien <= 1'b0;
        end else begin
            if (wr_control) begin
                control <= i_wdata & tbdo_pkg::CONTROL_MASK;
            end
            if (wr_ien) begin
                tick_ien <= i_wdata[tbdo_pkg::STAT_TICK_BIT];
            end
        end
    end

    // ****************************************
    // tick edge detect
    // ****************************************
    // a control write may move the tap, so the edge detector rests one
    // cycle to avoid a false edge from the old tap
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_tap <= 1'b0;
            armed <= 1'b0;
            o_tick_interrupt <= 1'b0;
        end else begin
            prev_tap <= tap;
            armed <= tick_en && !wr_control;
            o_tick_interrupt <= tick_event;
        end
    end

    // ****************************************
    // interrupt status, set wins over clear
    // ****************************************
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tick_stat <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            tick_stat <= tick_event || (tick_stat &&
                         !(wr_clear && i_wdata[tbdo_pkg::STAT_TICK_BIT]));
            o_irq <= tick_stat && tick_ien;
        end
    end

    // ****************************************
    // tone pin and read data
    // ****************************************
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tone_out_n <= 1'b1;
            o_rdata <= 8'h00;
        end else begin
            o_tone_out_n <= tone_en ? !tone_tap : 1'b1;
            o_rdata <= i_rd ? next_rdata : 8'h00;
        end
    end
endmodule
`default_nettype wire

// >>> testbench/tbdo_buzzer.sv
// buzzer and interrupt controller model for the time base bench
`timescale 1ns/10ps
`default_nettype none
module tbdo_buzzer (
    // clock and window clear
    input wire logic i_mclk,
    input wire logic i_clr,
    // device pins
    input wire logic o_tone_out_n,
    input wire logic o_tick_interrupt,
    // counts over the window
    output int o_ticks,
    output int o_falls,
    output int o_low
);
    logic last = 1'b1;
    always @(posedge i_mclk) begin
        last <= o_tone_out_n;
        o_ticks <= i_clr ? 0 : o_ticks + o_tick_interrupt;
        o_falls <= i_clr ? 0 : o_falls + (last & !o_tone_out_n);
        o_low <= i_clr ? 0 : o_low + !o_tone_out_n;
    end
endmodule
`default_nettype wire

// >>> testbench/tbdo_checker.sv
// port checker for the time base block
`timescale 1ns/10ps
`default_nettype none
module tbdo_checker (
    input wire logic i_mclk, i_rst_n, i_high_freq_clock, i_low_freq_clock,
    input wire logic i_divider_chain_source_select, i_slow_mode, i_wr, i_rd,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata, o_rdata,
    input wire logic o_tick_interrupt, o_irq, o_tone_out_n
);
    // mirror of control and chain; rate only changes while quiet
    logic [7:0] ctl;
    logic [22:0] ch;
    logic tq;
    int q;
    wire lf = i_divider_chain_source_select | i_slow_mode;
    wire [2:0] c = ctl[2:0];
    wire [4:0] tb = 5'((c == 0 ? 23 : c == 1 ? 21 : c == 2 ? 16 : c == 7 ? 9 : 17 - c) - (lf ? 9 : 1));
    wire [4:0] tn = 5'((lf ? 4 : 12) - ctl[6:5]);
    wire fa = tq & ~ch[tb] & (!i_slow_mode || c < 2);
    wire fl = fa & ctl[3] & (q > 8);
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctl <= 8'h00;
            ch <= '0;
            tq <= 1'b0;
            q <= 0;
        end else begin
            if (i_wr && i_addr == tbdo_pkg::ADDR_CONTROL) ctl <= i_wdata & tbdo_pkg::CONTROL_MASK;
            if (lf ? i_low_freq_clock : i_high_freq_clock) ch <= ch + 23'h1;
            tq <= ch[tb];
            q <= i_wr ? 0 : q + (q < 9);
        end
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    a_reset_idle: assert property ($rose(i_rst_n) |-> o_tone_out_n && !o_irq && !o_tick_interrupt)
        else $error("outputs not idle after reset");
    a_tick_single: assert property (o_tick_interrupt |=> !o_tick_interrupt)
        else $error("tick longer than one cycle");
    a_tick_on_fall: assert property (fl |-> ##[0:2] o_tick_interrupt)
        else $error("tap fell without tick");
    a_tick_cause: assert property (o_tick_interrupt |-> (fa || $past(fa) || $past(fa, 2)) && ($past(ctl[3]) || $past(ctl[3], 2)))
        else $error("tick without enabled tap fall");
    a_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("read data outside answer cycle");
    a_read_back: assert property (i_rd && i_addr == tbdo_pkg::ADDR_CONTROL |=> o_rdata == ctl)
        else $error("control read back wrong");
    a_tone_off: assert property (!ctl[7] && !$past(ctl[7]) |-> o_tone_out_n)
        else $error("tone pin low while disabled");
    a_tone_wave: assert property (ctl[7] && $past(ctl[7]) |-> o_tone_out_n != $past(ch[tn]))
        else $error("tone not following chain tap");
endmodule
bind tbdo_time_base tbdo_checker chk (.i_mclk, .i_rst_n, .i_high_freq_clock, .i_low_freq_clock,
    .i_divider_chain_source_select, .i_slow_mode, .i_wr, .i_rd, .i_addr, .i_wdata, .o_rdata,
    .o_tick_interrupt, .o_irq, .o_tone_out_n);
`default_nettype wire

// >>> testbench/time_base_and_divider_output_tb.sv
// self-checking bench for the time base block
`timescale 1ns/10ps
`default_nettype none
module time_base_and_divider_output_tb;
    logic i_mclk = 0, i_rst_n = 0, i_high_freq_clock = 0, i_low_freq_clock = 0, i_slow_mode = 0;
    logic i_divider_chain_source_select = 0, i_wr = 0, i_rd = 0, clr = 0;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00;
    wire logic [7:0] o_rdata;
    wire logic o_tick_interrupt, o_irq, o_tone_out_n;
    int n_errors = 0, n_compared = 0, cyc = 0, ticks, falls, low, e, p;
    tbdo_time_base uut (.i_mclk, .i_rst_n, .i_high_freq_clock, .i_low_freq_clock,
        .i_divider_chain_source_select, .i_slow_mode, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .o_tick_interrupt, .o_irq, .o_tone_out_n);
    tbdo_buzzer bz (.i_mclk, .i_clr(clr), .o_tone_out_n, .o_tick_interrupt, .o_ticks(ticks),
        .o_falls(falls), .o_low(low));
    always #5 i_mclk = ~i_mclk;
    // fast source pulses; timeout well above the ~63k cycle run
    always @(posedge i_mclk) begin
        i_high_freq_clock <= 1'b1;
        i_low_freq_clock <= ~i_low_freq_clock;
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            n_errors++;
            give_verdict;
        end
    end
    task chk(logic [7:0] g, logic [7:0] x);
        n_compared++;
        if (g !== x) begin
            n_errors++;
            $display("CHECK FAILED %0t got %h expected %h", $time, g, x);
        end
    endtask
    task idle(int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    task wr_reg(logic [3:0] a, logic [7:0] d);
        @(posedge i_mclk) {i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
        @(posedge i_mclk) i_wr <= 1'b0;
    endtask
    task rd_chk(logic [3:0] a, logic [7:0] x);
        @(posedge i_mclk) {i_addr, i_rd} <= {a, 1'b1};
        @(posedge i_mclk) i_rd <= 1'b0;
        #1 chk(o_rdata, x);
    endtask
    task count(int w);
        @(posedge i_mclk) clr <= 1'b1;
        @(posedge i_mclk) clr <= 1'b0;
        idle(w);
    endtask
    task give_verdict;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        rd_chk(tbdo_pkg::ADDR_CONTROL, 8'h00);
        chk({7'h0, o_tone_out_n}, 8'h01);
        wr_reg(tbdo_pkg::ADDR_CONTROL, 8'h67);
        rd_chk(tbdo_pkg::ADDR_CONTROL, 8'h67);
        wr_reg(tbdo_pkg::ADDR_CONTROL, 8'h10);
        rd_chk(tbdo_pkg::ADDR_CONTROL, 8'h00);
        $display("test registers done");
        for (int s = 0; s < 2; s++) begin
            for (int c = s ? 2 : 4; c < 8; c++) begin
                e = c == 2 ? 16 : c == 7 ? 9 : 17 - c;
                p = s ? 1 << (e - 7) : 1 << e;
                @(posedge i_mclk) i_divider_chain_source_select <= s[0];
                wr_reg(tbdo_pkg::ADDR_CONTROL, 8'h08 | 8'(c));
                idle(4);
                count(2 * p);
                chk(ticks[7:0], 8'h02);
                wr_reg(tbdo_pkg::ADDR_CONTROL, 8'(c));
            end
        end
        count(64);
        chk(ticks[7:0], 8'h00);
        @(posedge i_mclk) i_slow_mode <= 1'b1;
        wr_reg(tbdo_pkg::ADDR_CONTROL, 8'h0a);
        idle(4);
        count(1024);
        chk(ticks[7:0], 8'h00);
        wr_reg(tbdo_pkg::ADDR_CONTROL, 8'h02);
        @(posedge i_mclk) {i_slow_mode, i_divider_chain_source_select} <= 2'b00;
        $display("test ticks done");
        rd_chk(tbdo_pkg::ADDR_STATUS, 8'h01);
        chk({7'h0, o_irq}, 8'h00);
        wr_reg(tbdo_pkg::ADDR_IRQ_ENABLE, 8'h01);
        idle(2);
        chk({7'h0, o_irq}, 8'h01);
        wr_reg(tbdo_pkg::ADDR_IRQ_CLEAR, 8'h01);
        rd_chk(tbdo_pkg::ADDR_STATUS, 8'h00);
        chk({7'h0, o_irq}, 8'h00);
        rd_chk(tbdo_pkg::ADDR_IRQ_CLEAR, 8'h00);
        wr_reg(4'hf, 8'hff);
        rd_chk(4'hf, 8'h00);
        rd_chk(tbdo_pkg::ADDR_CONTROL, 8'h02);
        $display("test interrupt done");
        for (int c = 0; c < 4; c++) begin
            wr_reg(tbdo_pkg::ADDR_CONTROL, 8'(c << 5));
            wr_reg(tbdo_pkg::ADDR_CONTROL, 8'h80 | 8'(c << 5));
            idle(4);
            count(2 << (13 - c));
            chk(falls[7:0], 8'h02);
            chk({7'h0, low == (2 << (12 - c))}, 8'h01);
            wr_reg(tbdo_pkg::ADDR_CONTROL, 8'(c << 5));
        end
        $display("test tone done");
        give_verdict;
    end
endmodule
`default_nettype wire
